// [rtl/scp_pkg.sv]
/*
   Constants shared by the four-wire serial control port slave.
   Assumes a 100 MHz system clock that oversamples the host's serial pins.
*/
package scp_pkg;

   // ----------------------------------------------------------------
   // Frame layout
   // ----------------------------------------------------------------
   localparam int FRAME_BITS = 16;        // Bits in one frame.
   localparam int ADDR_BITS = 7;          // Register address width.
   localparam int DATA_BITS = 8;          // Register data width.
   localparam int CNT_BITS = 5;           // Width of the bit counter.
   localparam logic [4:0] DIR_BIT_POS = 5'h08;   // Count after address and direction.
   localparam logic [4:0] LAST_BIT_POS = 5'h10;  // Count when the frame is complete.
   localparam logic [7:0] DATA_RESET = 8'h00;    // Reset value of the shift data.

   // ----------------------------------------------------------------
   // Synchroniser
   // ----------------------------------------------------------------
   localparam int SYNC_STAGES = 3;        // Flip-flops on each pin input.
   // Idle level per pin, bit order {mode, data in, select, clock}.
   // Select idles high, and mode idles high so the port reports four-wire after reset.
   localparam logic [3:0] PIN_IDLE = 4'hA;

endpackage

// [rtl/scp_pin_if.sv]
/*
   Bundle of synchronised serial pin levels and edge strobes.
   Assumes the producer runs on the same clock as every consumer.
*/
`timescale 1ns/100ps
`default_nettype none

interface scp_pin_if;
   logic sckRise;   // One-cycle pulse on a rising serial clock edge.
   logic sckFall;   // One-cycle pulse on a falling serial clock edge.
   logic selLow;    // Agreed level: slave select is low.
   logic dataIn;    // Agreed level of the serial input pin.
   logic modeSel;   // Agreed level of the interface select pin.

   modport producer (output sckRise, output sckFall, output selLow, output dataIn,
      output modeSel);
   modport consumer (input sckRise, input sckFall, input selLow, input dataIn,
      input modeSel);
endinterface

`default_nettype wire

// [rtl/scp_pin_sync.sv]
/*
   Three-stage synchronisers and edge detection for the serial pins.
   Assumes the pins are asynchronous to mclk; a change counts once the
   second and third stages agree.
*/
`timescale 1ns/100ps
`default_nettype none

module scp_pin_sync
   import scp_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic sckPin,
   input wire logic selPin_n,
   input wire logic dinPin,
   input wire logic modePin,
   scp_pin_if.producer pins
);

   // ----------------------------------------------------------------
   // Synchroniser chains
   // ----------------------------------------------------------------
   logic [SYNC_STAGES-1:0] chain_r [4];   // One chain per pin.
   logic [3:0] agreed_r;                  // Last agreed level per pin.
   logic [3:0] rawIn;                     // Pins gathered into a vector.

   assign rawIn = {modePin, dinPin, selPin_n, sckPin};

   // Each pin shifts through its chain; agreed level moves when stages 2 and 3 match.
   generate
      for (genvar i = 0; i < 4; i++)
      begin : g_pin
         always_ff @(posedge mclk)
         begin
            if (!rst_n)
            begin
               // Every stage starts at the pin's idle level, so no false edge follows reset.
               chain_r[i] <= {SYNC_STAGES{PIN_IDLE[i]}};
               agreed_r[i] <= PIN_IDLE[i];
            end
            else
            begin
               chain_r[i] <= {chain_r[i][SYNC_STAGES-2:0], rawIn[i]};
               if (chain_r[i][1] == chain_r[i][2])
               begin
                  agreed_r[i] <= chain_r[i][2];
               end
            end
         end
      end
   endgenerate

   // Edge strobes compare the new agreed serial clock against the old one.
   logic sckNew;
   assign sckNew = (chain_r[0][1] == chain_r[0][2]) ? chain_r[0][2] : agreed_r[0];

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         pins.sckRise <= 1'b0;
         pins.sckFall <= 1'b0;
      end
      else
      begin
         pins.sckRise <= sckNew & ~agreed_r[0];
         pins.sckFall <= ~sckNew & agreed_r[0];
      end
   end

   assign pins.selLow = ~agreed_r[1];
   assign pins.dataIn = agreed_r[2];
   assign pins.modeSel = agreed_r[3];

endmodule

`default_nettype wire

// [rtl/serial_control_port_slave.sv]
/*
   Four-wire serial slave port carrying 16-bit register frames.
   Assumes a host whose serial clock is well below mclk/6, and a register
   file outside that takes write strobes and answers read addresses at once.
*/
`timescale 1ns/100ps
`default_nettype none

module serial_control_port_slave
   import scp_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic sckPin,
   input wire logic selPin_n,
   input wire logic dinPin,
   input wire logic ifModePin,
   output logic doutPin,
   output logic doutOe_n,
   output logic twoWireMode,
   output logic [scp_pkg::ADDR_BITS-1:0] regAddr,
   output logic [scp_pkg::DATA_BITS-1:0] regWrData,
   output logic regWrStb,
   output logic regRdStb,
   input wire logic [scp_pkg::DATA_BITS-1:0] regRdData
);
   import scp_pkg::*;

   // ----------------------------------------------------------------
   // Pin synchronisation
   // ----------------------------------------------------------------
   scp_pin_if pins ();   // Synchronised pin bundle.

   scp_pin_sync u_sync (
      .mclk(mclk),
      .rst_n(rst_n),
      .sckPin(sckPin),
      .selPin_n(selPin_n),
      .dinPin(dinPin),
      .modePin(ifModePin),
      .pins(pins)
   );

   // ----------------------------------------------------------------
   // Frame state
   // ----------------------------------------------------------------
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,    // Waiting for select.
      ST_ADDR = 2'b01,    // Receiving address and direction.
      ST_WDATA = 2'b10,   // Receiving write data.
      ST_RDATA = 2'b11    // Sending read data.
   } phase_e;

   phase_e phase_r;              // Current frame phase.
   logic [CNT_BITS-1:0] bitCnt_r; // Bits taken so far in this frame.
   logic [7:0] shiftIn_r;        // Incoming shift register.
   logic [7:0] shiftOut_r;       // Outgoing read byte.
   logic portOn;                 // Serial port is selected and enabled.

   // Port is live only in four-wire mode with select held low.
   assign portOn = pins.modeSel & pins.selLow;

   // Bit counter; cleared whenever select rises or the port is off.
   always_ff @(posedge mclk)
   begin
      if (!rst_n || !portOn)
      begin
         bitCnt_r <= '0;
      end
      else if (pins.sckRise && bitCnt_r != LAST_BIT_POS)
      begin
         bitCnt_r <= bitCnt_r + 5'h01;
      end
   end

   // Input shift register samples on the serial clock rising edge.
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         shiftIn_r <= DATA_RESET;
      end
      else if (portOn && pins.sckRise && bitCnt_r != LAST_BIT_POS)
      begin
         shiftIn_r <= {shiftIn_r[6:0], pins.dataIn};
      end
   end

   // Phase machine: address, then write or read data, idle on select high.
   always_ff @(posedge mclk)
   begin
      if (!rst_n || !portOn)
      begin
         phase_r <= ST_IDLE;
      end
      else
      begin
         unique case (phase_r)
            ST_IDLE:
            begin
               phase_r <= ST_ADDR;
            end
            ST_ADDR:
            begin
               // Eighth rising edge carries the direction bit.
               if (pins.sckRise && bitCnt_r == DIR_BIT_POS - 5'h01)
               begin
                  phase_r <= pins.dataIn ? ST_WDATA : ST_RDATA;
               end
            end
            ST_WDATA, ST_RDATA:
            begin
               phase_r <= phase_r;   // Held until select rises.
            end
         endcase
      end
   end

   // Address capture once the seventh address bit is in.
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         regAddr <= '0;
      end
      else if (phase_r == ST_ADDR && pins.sckRise && bitCnt_r == DIR_BIT_POS - 5'h01)
      begin
         regAddr <= shiftIn_r[6:0];
      end
   end

   // Read strobe one cycle after the direction bit selects a read.
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         regRdStb <= 1'b0;
      end
      else
      begin
         regRdStb <= portOn && phase_r == ST_ADDR && pins.sckRise
            && bitCnt_r == DIR_BIT_POS - 5'h01 && !pins.dataIn;
      end
   end

   // Write strobe after the sixteenth bit of a write frame.
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         regWrStb <= 1'b0;
         regWrData <= DATA_RESET;
      end
      else
      begin
         regWrStb <= 1'b0;
         if (portOn && phase_r == ST_WDATA && pins.sckRise
            && bitCnt_r == LAST_BIT_POS - 5'h01)
         begin
            regWrStb <= 1'b1;
            regWrData <= {shiftIn_r[6:0], pins.dataIn};
         end
      end
   end

   // ----------------------------------------------------------------
   // Read data output
   // ----------------------------------------------------------------
   // Byte is loaded after the read strobe; bits move on falling edges.
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         shiftOut_r <= DATA_RESET;
         doutPin <= 1'b0;
      end
      else if (regRdStb)
      begin
         shiftOut_r <= regRdData;
      end
      else if (portOn && phase_r == ST_RDATA && pins.sckFall
         && bitCnt_r != LAST_BIT_POS)
      begin
         doutPin <= shiftOut_r[7];
         shiftOut_r <= {shiftOut_r[6:0], 1'b0};
      end
   end

   // Output driven only from the first data fall until select rises.
   always_ff @(posedge mclk)
   begin
      if (!rst_n || !portOn || phase_r != ST_RDATA)
      begin
         doutOe_n <= 1'b1;
      end
      else if (pins.sckFall && bitCnt_r != LAST_BIT_POS)
      begin
         doutOe_n <= 1'b0;
      end
   end

   // Protocol choice reported to the two-wire logic outside.
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         twoWireMode <= 1'b0;
      end
      else
      begin
         twoWireMode <= ~pins.modeSel;
      end
   end

endmodule

`default_nettype wire

// [testbench/scp_properties.sv]
/* Pin-level checks for the serial control port slave.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/100ps
`default_nettype none

module scp_properties
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic sckPin,
   input wire logic selPin_n,
   input wire logic ifModePin,
   input wire logic doutPin,
   input wire logic doutOe_n,
   input wire logic twoWireMode,
   input wire logic regWrStb,
   input wire logic regRdStb
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);

   mode_two_a: assert property ((!ifModePin)[*8] |-> twoWireMode)
      else $error("two-wire mode not taken");
   mode_four_a: assert property (ifModePin[*8] |-> !twoWireMode)
      else $error("four-wire mode not taken");
   mode_quiet_a: assert property (twoWireMode |-> !regWrStb && !regRdStb)
      else $error("strobe in two-wire mode");
   out_idle_a: assert property (selPin_n[*8] |-> doutOe_n)
      else $error("output driven while idle");
   strobe_excl_a: assert property (!(regWrStb && regRdStb))
      else $error("read and write strobe together");
   out_write_a: assert property (regWrStb |-> doutOe_n)
      else $error("output driven during a write frame");
   rd_drive_a: assert property (regRdStb |-> ##[1:40] !doutOe_n)
      else $error("read data never driven");
   wr_frame_a: assert property (regWrStb |-> !$past(selPin_n, 4) && $past(sckPin, 4))
      else $error("write strobe not after a clock rise");
   dout_fall_a: assert property ($changed(doutPin) && !doutOe_n |-> !$past(sckPin, 4))
      else $error("output changed off a falling edge");

   // Main scenarios are reached.
   cover property (regWrStb);
   cover property (regRdStb);
   cover property ($fell(doutOe_n));
endmodule

bind serial_control_port_slave scp_properties u_scp_properties (.mclk(mclk), .rst_n(rst_n),
   .sckPin(sckPin), .selPin_n(selPin_n), .ifModePin(ifModePin), .doutPin(doutPin),
   .doutOe_n(doutOe_n), .twoWireMode(twoWireMode), .regWrStb(regWrStb),
   .regRdStb(regRdStb));

`default_nettype wire

// [testbench/scp_host_model.sv]
/* Host serial master model driving frames on the slave's pins.
   Assumes the bench resolves the output line, pulled up when released. */
`timescale 1ns/100ps
`default_nettype none

module scp_host_model
(
   output logic sckPin,
   output logic selPin_n,
   output logic dinPin,
   input wire logic soLine
);
   int hp = 80; // Half period of the serial clock in ns.

   // Clock idles low and stands still between frames.
   initial
   begin
      sckPin = 1'b0;
      selPin_n = 1'b1;
      dinPin = 1'b0;
   end

   // One frame of nb bits; bits 9 to 16 are gathered from the line.
   task automatic xfer(input logic [15:0] f, input int nb, output logic [7:0] r);
      r = 8'h00;
      selPin_n = 1'b0;
      for (int i = 0; i < nb; i++)
      begin
         dinPin = (i < 16) ? f[15 - i] : ~dinPin;
         #hp sckPin = 1'b1;
         if (i >= 8 && i < 16)
            r = {r[6:0], soLine};
         #hp sckPin = 1'b0;
      end
      #hp selPin_n = 1'b1;
      dinPin = ~dinPin;
      #(2 * hp);
   endtask
endmodule

`default_nettype wire

// [testbench/serial_control_port_slave_bench.sv]
/* Self-checking bench for the serial control port slave.
   Assumes the host model drives the pins and a table here plays the register file. */
`timescale 1ns/100ps
`default_nettype none

module serial_control_port_slave_bench;
   import scp_pkg::*;
   typedef struct {logic w; logic [6:0] a; logic [7:0] d;} row_s;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic ifModePin = 1'b1;
   logic sckPin, selPin_n, dinPin, doutPin, doutOe_n, twoWireMode, regWrStb, regRdStb;
   logic [6:0] regAddr;
   logic [7:0] regWrData, rd;
   logic [7:0] mem [128];
   int n_fail = 0, comparisons = 0, nWr = 0, nRd = 0, w0, r0;
   wire logic soLine = doutOe_n ? 1'b1 : doutPin; // Pull-up when released.
   wire logic [7:0] regRdData = mem[regAddr];
   row_s rows [8] = '{'{1'b1, 7'h55, 8'hA5}, '{1'b1, 7'h2A, 8'h5A}, '{1'b1, 7'h7F, 8'hFF},
      '{1'b1, 7'h00, 8'h01}, '{1'b0, 7'h55, 8'hA5}, '{1'b0, 7'h7F, 8'hFF},
      '{1'b0, 7'h00, 8'h01}, '{1'b0, 7'h2A, 8'h5A}};

   always #5 mclk = ~mclk;

   // Register file: writes land on the strobe, strobes are counted.
   always @(posedge mclk)
   begin
      if (regWrStb)
      begin
         nWr++;
         mem[regAddr] <= regWrData;
      end
      if (regRdStb)
         nRd++;
   end

   serial_control_port_slave u_serial_control_port_slave (.mclk(mclk), .rst_n(rst_n),
      .sckPin(sckPin), .selPin_n(selPin_n), .dinPin(dinPin), .ifModePin(ifModePin),
      .doutPin(doutPin), .doutOe_n(doutOe_n), .twoWireMode(twoWireMode), .regAddr(regAddr),
      .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
      .regRdData(regRdData));
   scp_host_model u_scp_host_model (.sckPin(sckPin), .selPin_n(selPin_n), .dinPin(dinPin),
      .soLine(soLine));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("comparisons %0d, n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Read frames carry inverted data so an echo of the input is caught.
   task automatic frame(input row_s r, input int nb);
      @(posedge mclk);
      #1;
      w0 = nWr;
      r0 = nRd;
      u_scp_host_model.xfer({r.a, r.w, r.w ? r.d : ~r.d}, nb, rd);
   endtask

   // Table rows, then the awkward cases.
   initial
   begin
      repeat (2) @(posedge mclk);
      #1 check({7'h00, doutOe_n}, 8'h01);
      check({7'h00, twoWireMode}, 8'h00);
      rst_n = 1'b1;
      repeat (3) @(posedge mclk);
      #1 check({7'h00, twoWireMode}, 8'h00);
      repeat (3) @(posedge mclk);
      foreach (rows[i])
      begin
         frame(rows[i], 16);
         check({1'b0, regAddr}, {1'b0, rows[i].a});
         if (rows[i].w)
         begin
            check(8'(nWr - w0), 8'h01);
            check(regWrData, rows[i].d);
         end
         else
         begin
            check(8'(nRd - r0), 8'h01);
            check(rd, rows[i].d);
         end
      end
      frame('{1'b1, 7'h11, 8'h3C}, 20);
      check(8'(nWr - w0), 8'h01);
      check(regWrData, 8'h3C);
      frame('{1'b1, 7'h12, 8'h77}, 12);
      check(8'(nWr - w0), 8'h00);
      frame('{1'b0, 7'h11, 8'h3C}, 16);
      check(rd, 8'h3C);
      check({7'h00, doutOe_n}, 8'h01);
      u_scp_host_model.hp = 200;
      frame('{1'b0, 7'h55, 8'hA5}, 16);
      check(rd, 8'hA5);
      u_scp_host_model.hp = 80;
      @(posedge mclk) #1 ifModePin = 1'b0;
      repeat (8) @(posedge mclk);
      check({7'h00, twoWireMode}, 8'h01);
      frame('{1'b1, 7'h55, 8'h00}, 16);
      check(8'(nWr - w0 + nRd - r0), 8'h00);
      @(posedge mclk) #1 ifModePin = 1'b1;
      repeat (8) @(posedge mclk);
      check({7'h00, twoWireMode}, 8'h00);
      frame('{1'b0, 7'h55, 8'hA5}, 16);
      check(rd, 8'hA5);
      conclude();
   end

   // Watchdog well past the expected run of about 44 us.
   initial
   begin
      #300000;
      n_fail++;
      conclude();
   end
endmodule

`default_nettype wire
